// ==== pkg/dls_pkg.sv ====
// Constants and types shared by the display link serializer and its FIFO.
// Assumes a single 40 MHz core clock; all link pins are sampled by it.
`default_nettype none
package dls_pkg;
   // ------------------------------------------------------------
   // Word and lane geometry
   // ------------------------------------------------------------
   localparam int unsigned DLS_WORD_W    = 28;     // Parallel pixel word
   localparam int unsigned DLS_LANES     = 4;      // Serial data lanes
   localparam int unsigned DLS_SLOTS     = 7;      // Bits per lane per word
   localparam int unsigned DLS_FIFO_D    = 32;     // Words buffered
   // Forwarded clock pattern, slot 0 first: two high, three low, two high
   localparam logic [6:0]  DLS_CLK_PAT   = 7'h63;
   localparam logic [27:0] DLS_IDLE_WORD = 28'h0000000;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned DLS_MCLK_MHZ   = 40;    // Core clock rate
   localparam int unsigned DLS_STRB_MIN_MHZ = 20;  // Slowest strobe clock
   localparam int unsigned DLS_STRB_MAX_MHZ = 85;  // Fastest strobe clock
   // Longest legal strobe period in core cycles, rounded up
   localparam int unsigned DLS_STRB_MAX_CYC =
      (DLS_MCLK_MHZ + DLS_STRB_MIN_MHZ - 1) / DLS_STRB_MIN_MHZ;
   // No edge for this many cycles means the strobe clock has stopped
   localparam logic [7:0]  DLS_STALL_CYC = 8'(DLS_STRB_MAX_CYC * 32);
   localparam logic [7:0]  DLS_FREE_PER  = 8'h08;  // Free-running period
   localparam logic [7:0]  DLS_PER_MIN   = 8'h07;  // One slot per cycle
   localparam logic [7:0]  DLS_PER_RST   = 8'h08;  // Period after reset
   localparam logic [2:0]  DLS_SLOT_LAST = 3'h6;
   // Serializer state
   typedef enum logic [1:0] {DLS_OFF, DLS_FREE, DLS_LOCKED} dls_mode_t;
endpackage
`default_nettype wire

// ==== core/dls_fifo.sv ====
// Synchronous FIFO of flip-flops with valid/ready on both sides.
// Assumes one clock, asynchronous active-high reset and a clock enable.
`default_nettype none
module dls_fifo
   import dls_pkg::*;
#(
   parameter int unsigned WIDTH = DLS_WORD_W,
   parameter int unsigned DEPTH = DLS_FIFO_D
) (
   input  wire logic             clk_in,      // Core clock
   input  wire logic             rst_in,      // Async reset, high
   input  wire logic             ce_in,       // Clock enable
   input  wire logic             in_valid_in, // Word offered
   output logic                  in_ready_out,// Space free
   input  wire logic [WIDTH-1:0] in_data_in,  // Word in
   output logic                  out_valid_out,// Word available
   input  wire logic             out_ready_in,// Word taken
   output logic [WIDTH-1:0]      out_data_out // Oldest word
);
   localparam int unsigned AW = $clog2(DEPTH);
   // ------------------------------------------------------------
   // Storage and pointers
   // ------------------------------------------------------------
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q, rd_q;
   logic [AW:0]      cnt_q;
   wire              push_w = in_valid_in && in_ready_out;
   wire              pop_w  = out_valid_out && out_ready_in;

   // Full and empty from the fill count
   assign in_ready_out  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid_out = (cnt_q != '0);
   assign out_data_out  = mem_q[rd_q];

   // Word storage, no reset needed
   always_ff @(posedge clk_in) begin
      if (ce_in && push_w) mem_q[wr_q] <= in_data_in;
   end

   // Pointer and count update
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else if (ce_in) begin
         if (push_w) wr_q <= AW'(wr_q + 1'b1);
         if (pop_w) rd_q <= AW'(rd_q + 1'b1);
         cnt_q <= (AW+1)'(cnt_q + push_w - pop_w);
      end
   end
endmodule
`default_nettype wire

// ==== core/dls_serializer.sv ====
// Transmit side of a 28-to-4 flat-panel display link serializer.
// Assumes all pins are asynchronous to mclk_in and are synchronised here;
// lane drivers are three-state, given as a level and an enable per line.
`default_nettype none
module dls_serializer
   import dls_pkg::*;
(
   input  wire logic                  mclk_in,                  // Core clock
   input  wire logic                  rst_in,                   // Async reset, high
   input  wire logic                  ce_in,                    // Clock enable
   input  wire logic [DLS_WORD_W-1:0] parallel_pixel_inputs_in, // Pixel word pins
   input  wire logic                  input_strobe_clock_in,    // Strobe clock pin
   input  wire logic                  strobe_edge_select_in,    // 1 rising, 0 falling
   input  wire logic                  power_down_n_in,          // Power-down, low
   output logic                       capture_ready_out,        // FIFO has space
   output logic [DLS_LANES-1:0]       serial_data_lanes_out,    // Lane levels
   output logic [DLS_LANES-1:0]       serial_data_lanes_oe_out, // Lane drive enables
   output logic                       forwarded_link_clock_out, // Clock lane level
   output logic                       forwarded_link_clock_oe_out // Clock lane enable
);
   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [DLS_WORD_W-1:0] pix_s1_q, pix_s2_q;
   logic [2:0]            ctl_s1_q, ctl_s2_q;
   logic                  strb_d1_q;

   // Two flops on every pin before any logic
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         pix_s1_q <= '0;
         pix_s2_q <= '0;
         ctl_s1_q <= '0;
         ctl_s2_q <= '0;
         strb_d1_q <= 1'b0;
      end else if (ce_in) begin
         pix_s1_q <= parallel_pixel_inputs_in;
         pix_s2_q <= pix_s1_q;
         ctl_s1_q <= {power_down_n_in, strobe_edge_select_in, input_strobe_clock_in};
         ctl_s2_q <= ctl_s1_q;
         strb_d1_q <= ctl_s2_q[0];
      end
   end

   wire strb_w    = ctl_s2_q[0];
   wire rise_sel_w = ctl_s2_q[1];
   wire pwr_on_w  = ctl_s2_q[2];

   // ------------------------------------------------------------
   // Strobe edge detection and capture
   // ------------------------------------------------------------
   wire rise_w   = strb_w && !strb_d1_q;
   wire fall_w   = !strb_w && strb_d1_q;
   wire strobe_w = rise_sel_w ? rise_w : fall_w;
   wire cap_w    = strobe_w && pwr_on_w;

   // Captured words queue for the serializer
   logic                  fifo_valid_w;
   logic [DLS_WORD_W-1:0] fifo_data_w;
   logic                  fifo_pop_w;

   dls_fifo #(
      .WIDTH (DLS_WORD_W),
      .DEPTH (DLS_FIFO_D)
   ) u_fifo (
      .clk_in        (mclk_in),
      .rst_in        (rst_in),
      .ce_in         (ce_in),
      .in_valid_in   (cap_w),
      .in_ready_out  (capture_ready_out),
      .in_data_in    (pix_s2_q),
      .out_valid_out (fifo_valid_w),
      .out_ready_in  (fifo_pop_w),
      .out_data_out  (fifo_data_w)
   );

   // ------------------------------------------------------------
   // Strobe period tracking
   // ------------------------------------------------------------
   logic [7:0] gap_q, per_q;
   wire        stalled_w = (gap_q >= DLS_STALL_CYC);
   wire [7:0]  gap_inc_w = stalled_w ? gap_q : 8'(gap_q + 8'h01);
   wire [7:0]  meas_w    = (gap_inc_w < DLS_PER_MIN) ? DLS_PER_MIN : gap_inc_w;

   // Period between strobes, free period once stalled
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         gap_q <= '0;
         per_q <= DLS_PER_RST;
      end else if (ce_in) begin
         if (strobe_w) begin
            gap_q <= '0;
            per_q <= meas_w;
         end else begin
            gap_q <= gap_inc_w;
            if (stalled_w) per_q <= DLS_FREE_PER;
         end
      end
   end

   // ------------------------------------------------------------
   // Slot timing: seven slot ticks per measured period
   // ------------------------------------------------------------
   logic [7:0] acc_q;
   wire  [8:0] acc_sum_w = {1'b0, acc_q} + 9'(DLS_SLOTS);
   wire        tick_w    = (acc_sum_w >= {1'b0, per_q});
   wire  [8:0] acc_nxt_w = tick_w ? (acc_sum_w - {1'b0, per_q}) : acc_sum_w;

   // ------------------------------------------------------------
   // Serializer state
   // ------------------------------------------------------------
   dls_mode_t             mode_q, mode_d;
   logic [2:0]            slot_q;
   logic [DLS_WORD_W-1:0] word_q;
   wire  slot_end_w = tick_w && (slot_q == DLS_SLOT_LAST);
   // A new frame starts on each strobe, or wraps when free-running
   wire  frame_w    = pwr_on_w && (strobe_w || slot_end_w);
   wire  locked_w   = !stalled_w || strobe_w;

   assign fifo_pop_w = frame_w && fifo_valid_w;

   // Mode follows power-down and strobe activity
   always_comb begin
      mode_d = mode_q;
      unique case (mode_q)
         DLS_OFF:    if (pwr_on_w) mode_d = locked_w ? DLS_LOCKED : DLS_FREE;
         DLS_FREE:   if (!pwr_on_w) mode_d = DLS_OFF; else if (locked_w) mode_d = DLS_LOCKED;
         DLS_LOCKED: if (!pwr_on_w) mode_d = DLS_OFF; else if (!locked_w) mode_d = DLS_FREE;
      endcase
   end

   // Frame restart on the strobe keeps the clock lane in phase
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         mode_q <= DLS_OFF;
         slot_q <= '0;
         acc_q  <= '0;
         word_q <= DLS_IDLE_WORD;
      end else if (ce_in) begin
         mode_q <= mode_d;
         if (!pwr_on_w) begin
            slot_q <= '0;
            acc_q  <= '0;
         end else if (frame_w) begin
            slot_q <= '0;
            acc_q  <= '0;
            word_q <= fifo_valid_w ? fifo_data_w : DLS_IDLE_WORD;
         end else begin
            acc_q <= acc_nxt_w[7:0];
            if (tick_w) slot_q <= 3'(slot_q + 3'h1);
         end
      end
   end

   // ------------------------------------------------------------
   // Lane bit selection
   // ------------------------------------------------------------
   // Lane l, slot s carries word bit l*7 + (6 - s), most significant first
   function automatic logic lane_bit(input logic [DLS_WORD_W-1:0] w,
                                     input int unsigned lane,
                                     input logic [2:0] slot);
      lane_bit = w[lane * DLS_SLOTS + (DLS_SLOTS - 1) - 32'(slot)];
   endfunction

   logic [DLS_LANES-1:0] lane_d;
   logic [DLS_LANES-1:0] lane_q;
   logic                 clk_q;
   wire                  drive_w = (mode_q != DLS_OFF);
   wire                  drive_nxt_w = (mode_d != DLS_OFF);
   wire                  clk_d   = DLS_CLK_PAT[DLS_SLOT_LAST - slot_q];

   genvar gl;
   generate
      for (gl = 0; gl < DLS_LANES; gl++) begin : g_lane
         assign lane_d[gl] = lane_bit(word_q, gl, slot_q);
      end
   endgenerate

   // Registered line levels, following the next mode so they drop with the enables
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         lane_q <= '0;
         clk_q  <= 1'b0;
      end else if (ce_in) begin
         lane_q <= drive_nxt_w ? lane_d : '0;
         clk_q  <= drive_nxt_w ? clk_d : 1'b0;
      end
   end

   // Drivers released while powered down
   assign serial_data_lanes_out       = lane_q;
   assign forwarded_link_clock_out    = clk_q;
   assign serial_data_lanes_oe_out    = {DLS_LANES{drive_w}};
   assign forwarded_link_clock_oe_out = drive_w;
endmodule
`default_nettype wire

// ==== test/dls_serializer_monitor.sv ====
// Pin-level checks of the serializer, bound into every instance.
// Assumes ce_in high whenever the pins are meant to be judged.
`default_nettype none
module dls_serializer_monitor
   import dls_pkg::*;
(
   input wire logic                  mclk_in,                    // Core clock
   input wire logic                  rst_in,                     // Reset
   input wire logic                  ce_in,                      // Enable
   input wire logic [DLS_WORD_W-1:0] parallel_pixel_inputs_in,   // Pixels
   input wire logic                  input_strobe_clock_in,      // Strobe
   input wire logic                  strobe_edge_select_in,      // Edge sel
   input wire logic                  power_down_n_in,            // Power-down
   input wire logic                  capture_ready_out,          // Space
   input wire logic [DLS_LANES-1:0]  serial_data_lanes_out,      // Lanes
   input wire logic [DLS_LANES-1:0]  serial_data_lanes_oe_out,   // Lane oe
   input wire logic                  forwarded_link_clock_out,   // Clock lane
   input wire logic                  forwarded_link_clock_oe_out // Clock oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in || !ce_in);
   wire oe = forwarded_link_clock_oe_out;
   logic strb_p;
   // Strobe pin one cycle back, for edge detection outside the properties
   always_ff @(posedge mclk_in) begin
      strb_p <= input_strobe_clock_in;
   end
   // Selected edge: pin changed and now matches the select level
   wire sel_edge = (input_strobe_clock_in != strb_p) && (input_strobe_clock_in == strobe_edge_select_in);
   // Output enables and levels
   a_pd_lanes_off: assert property (!power_down_n_in [*3] |=> serial_data_lanes_oe_out == 4'h0)
      else $error("lanes driven in power down");
   a_run_oe_on: assert property (power_down_n_in [*3] |=> oe)
      else $error("clock lane not driven when running");
   a_oe_all_same: assert property (serial_data_lanes_oe_out == {4{oe}})
      else $error("lane enables differ");
   a_off_levels_low: assert property (!oe |-> serial_data_lanes_out == 4'h0 && !forwarded_link_clock_out)
      else $error("levels not low while off");
   // Forwarded clock behaviour and buffer ready after reset
   a_clock_free_run: assert property (oe |-> ##[1:100] ($changed(forwarded_link_clock_out) || !oe))
      else $error("forwarded clock stuck");
   a_clock_low_short: assert property (oe && !forwarded_link_clock_out |-> ##[1:5] (forwarded_link_clock_out || !oe))
      else $error("forwarded clock low too long");
   a_edge_clk_high: assert property (sel_edge && power_down_n_in && oe |-> ##[2:5] forwarded_link_clock_out)
      else $error("no frame start after strobe");
   a_ready_at_start: assert property ($fell(rst_in) |-> capture_ready_out)
      else $error("buffer not ready after reset");
   c_locked: cover property (sel_edge && oe ##3 forwarded_link_clock_out);
   c_power_down: cover property (!power_down_n_in [*3] ##1 !oe);
   c_falling_edge: cover property (!strobe_edge_select_in && sel_edge && oe);
endmodule
bind dls_serializer dls_serializer_monitor dls_serializer_monitor_i (.mclk_in, .rst_in, .ce_in,
   .parallel_pixel_inputs_in, .input_strobe_clock_in, .strobe_edge_select_in, .power_down_n_in,
   .capture_ready_out, .serial_data_lanes_out, .serial_data_lanes_oe_out, .forwarded_link_clock_out,
   .forwarded_link_clock_oe_out);
`default_nettype wire

// ==== test/dls_link_rx.sv ====
// Panel-side receiver model: rebuilds all seven slots of each frame.
// Assumes lanes and clock lane registered together by the serializer.
`default_nettype none
module dls_link_rx
   import dls_pkg::*;
(
   input  wire logic                 mclk_in,    // Core clock
   input  wire logic                 rst_in,     // Reset
   input  wire logic [DLS_LANES-1:0] lanes_in,   // Lane levels
   input  wire logic                 lclk_in,    // Clock lane
   input  wire logic                 lclk_oe_in, // Clock lane driven
   output logic                      frame_out,  // Frame seen
   output logic [DLS_WORD_W-1:0]     slots_out   // Slot s, lane l at bit s*4+l
);
   timeunit 1ns;
   timeprecision 1ps;
   logic                 lclk_q, tail_q;
   logic [3:0]           gap_q;
   logic [DLS_LANES-1:0] h1_q, h2_q;
   logic [23:0]          part_q;
   wire                  fall_w = lclk_q && !lclk_in && lclk_oe_in;
   wire                  rise_w = !lclk_q && lclk_in && lclk_oe_in;
   // Slots 0-1 precede the clock fall, 2 at it, 3-4 follow it, 5 at the rise, 6 one cycle on
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         lclk_q <= 1'b0;
         tail_q <= 1'b0;
         gap_q <= 4'hf;
         h1_q <= '0;
         h2_q <= '0;
         part_q <= '0;
         frame_out <= 1'b0;
         slots_out <= '0;
      end else begin
         lclk_q <= lclk_in;
         h1_q <= lanes_in;
         h2_q <= h1_q;
         frame_out <= 1'b0;
         tail_q <= 1'b0;
         if (gap_q != 4'hf) gap_q <= gap_q + 4'h1;
         if (gap_q == 4'h0) part_q[15:12] <= lanes_in;
         if (gap_q == 4'h1) part_q[19:16] <= lanes_in;
         if (fall_w) begin
            gap_q <= 4'h0;
            part_q[11:0] <= {lanes_in, h1_q, h2_q};
         end
         if (rise_w) begin
            tail_q <= gap_q >= 4'h2 && gap_q <= 4'h3;
            part_q[23:20] <= lanes_in;
         end
         if (tail_q) begin
            frame_out <= 1'b1;
            slots_out <= {lanes_in, part_q};
         end
      end
   end
endmodule
`default_nettype wire

// ==== test/dls_serializer_tb.sv ====
// Self-checking bench: random pixel words in, lane slots compared out.
// Assumes the monitor is bound and the receiver model sits on the lanes.
`default_nettype none
module dls_serializer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_in, rst_in, ce_in, input_strobe_clock_in, strobe_edge_select_in, power_down_n_in;
   logic [27:0] parallel_pixel_inputs_in;
   logic capture_ready_out, forwarded_link_clock_out, forwarded_link_clock_oe_out, frame, lc;
   logic [3:0] serial_data_lanes_out, serial_data_lanes_oe_out;
   logic [27:0] slots;
   logic [27:0] exp_q[$];
   logic [31:0] seed;
   int failures, compares, tog;
   dls_serializer dls_serializer_i (.mclk_in, .rst_in, .ce_in, .parallel_pixel_inputs_in,
      .input_strobe_clock_in, .strobe_edge_select_in, .power_down_n_in, .capture_ready_out,
      .serial_data_lanes_out, .serial_data_lanes_oe_out, .forwarded_link_clock_out,
      .forwarded_link_clock_oe_out);
   dls_link_rx dls_link_rx_i (.mclk_in, .rst_in, .lanes_in(serial_data_lanes_out),
      .lclk_in(forwarded_link_clock_out), .lclk_oe_in(forwarded_link_clock_oe_out),
      .frame_out(frame), .slots_out(slots));
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Slot s of lane l carries word bit l*7 + 6 - s, slot 0 first
   function automatic logic [27:0] exp_slots(input logic [27:0] w);
      for (int s = 0; s < 7; s++) begin
         for (int l = 0; l < 4; l++) begin
            exp_slots[s*4+l] = w[l*7+6-s];
         end
      end
   endfunction
   task automatic chk_frame(input string what, input logic [27:0] e, input logic [27:0] g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic give_verdict();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // One word per 8-cycle strobe period, selected edge mid-period
   task automatic burst(input logic s, input int n);
      logic [27:0] w;
      for (int i = 0; i < n; i++) begin
         w = i == 0 ? 28'hfffffff : i == 1 ? 28'h5555555 : i == 2 ? 28'h0000000 : 28'(rnd());
         @(negedge mclk_in);
         parallel_pixel_inputs_in = w;
         input_strobe_clock_in = !s;
         exp_q.push_back(w);
         repeat (4) @(negedge mclk_in);
         input_strobe_clock_in = s;
         repeat (3) @(negedge mclk_in);
      end
   endtask
   initial begin
      mclk_in = 1'b0;
      forever #12.5 mclk_in = ~mclk_in;
   end
   // Frames from the receiver model, idle zero frames skipped
   always @(negedge mclk_in) begin
      if (frame === 1'b1 && exp_q.size() > 0 && (slots != 28'h0 || exp_slots(exp_q[0]) == 28'h0)) begin
         chk_frame("frame", exp_slots(exp_q[0]), slots);
         void'(exp_q.pop_front());
      end
   end
   initial begin
      repeat (20000) @(posedge mclk_in);
      failures++;
      give_verdict();
   end
   initial begin
      {rst_in, ce_in, input_strobe_clock_in, strobe_edge_select_in, power_down_n_in} = 5'h1b;
      parallel_pixel_inputs_in = 28'h0000000;
      seed = 32'h00000031;
      repeat (10) @(posedge mclk_in);
      @(negedge mclk_in) rst_in = 1'b0;
      lc = 1'b0;
      repeat (100) begin
         @(negedge mclk_in);
         if (forwarded_link_clock_out !== lc) tog++;
         lc = forwarded_link_clock_out;
      end
      chk("free_run", 8'h01, 8'(tog >= 20));
      burst(1'b1, 20);
      // Let the last two words leave before the lanes are released
      repeat (24) @(negedge mclk_in);
      chk("drained_pd", 8'h00, 8'(exp_q.size()));
      power_down_n_in = 1'b0;
      repeat (6) @(negedge mclk_in);
      chk("oe_off", 8'h00, {3'h0, forwarded_link_clock_oe_out, serial_data_lanes_oe_out});
      strobe_edge_select_in = 1'b0;
      input_strobe_clock_in = 1'b1;
      repeat (80) @(negedge mclk_in);
      chk("oe_off_lvl", 8'h00, {3'h0, forwarded_link_clock_out, serial_data_lanes_out});
      power_down_n_in = 1'b1;
      repeat (6) @(negedge mclk_in);
      chk("oe_on", 8'h1f, {3'h0, forwarded_link_clock_oe_out, serial_data_lanes_oe_out});
      chk("ready", 8'h01, {7'h00, capture_ready_out});
      burst(1'b0, 12);
      repeat (200) @(negedge mclk_in);
      chk("drained", 8'h00, 8'(exp_q.size()));
      give_verdict();
   end
endmodule
`default_nettype wire
